// ---- rtl/atc_completion_builder.sv ----
`timescale 1ns/1ps
`default_nettype none
module atc_completion_builder #(
	parameter int LEVELS = atc_pkg::LEVELS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic pasid_valid,
	input wire atc_pkg::atc_xlate_e xlate_type,
	input wire logic [atc_pkg::ADDR_W-1:0] in_addr,
	input wire logic no_write_request_flag,
	input wire logic fetch_intent_requested,
	input wire logic supervisor_requested,
	input wire logic no_write_flag_supported,
	input wire logic fetch_intent_supported,
	input wire logic supervisor_mode_capable,
	input wire logic snoop_control_capable,
	input wire logic extended_accessed_enable,
	input wire logic [atc_pkg::WIDTH_W-1:0] max_guest_addr_width,
	input wire logic [atc_pkg::WIDTH_W-1:0] adjusted_guest_addr_width,
	input wire logic walk_found,
	input wire logic [LEVELS-1:0] sl_read_bits,
	input wire logic [LEVELS-1:0] sl_write_bits,
	input wire logic [LEVELS-1:0] sl_used_mask,
	input wire logic perm_read,
	input wire logic perm_write,
	input wire logic perm_exec,
	input wire logic any_fl_supervisor,
	input wire logic leaf_global,
	input wire logic coherence_override_bit,
	input wire logic transient_mapping_bit,
	input wire logic leaf_size_bit,
	input wire logic [atc_pkg::ADDR_W-1:0] out_addr,
	input wire logic [atc_pkg::ADDR_W-1:0] page_mask,
	input wire logic [LEVELS-1:0] fl_used_mask,
	input wire logic [atc_pkg::LVL_W-1:0] fl_leaf_level,
	output logic upd_valid,
	output logic [atc_pkg::LVL_W-1:0] upd_level,
	output logic [2:0] upd_set_mask,
	input wire logic upd_ready,
	input wire logic upd_committed,
	output logic cpl_valid,
	input wire logic cpl_ready,
	output logic [2:0] cpl_status,
	output logic cpl_r,
	output logic cpl_w,
	output logic cpl_exe,
	output logic cpl_priv,
	output logic cpl_g,
	output logic cpl_n,
	output logic cpl_u,
	output logic cpl_s,
	output logic [atc_pkg::ADDR_W-1:atc_pkg::PAGE_SHIFT] cpl_addr
);
	import atc_pkg::*;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Smaller of the two width limits; either may be the binding one
	function automatic logic [WIDTH_W-1:0] min_w(input logic [WIDTH_W-1:0] a, input logic [WIDTH_W-1:0] b);
		return (a < b) ? a : b;
	endfunction
	function automatic logic and_used(input logic [LEVELS-1:0] bits, input logic [LEVELS-1:0] used);
		return &(bits | ~used);
	endfunction
	// Large page: offset bits below the top one forced to ones, the top offset bit zero marks the size
	function automatic logic [ADDR_W-1:PAGE_SHIFT] size_encode(input logic [ADDR_W-1:0] addr,
			input logic [ADDR_W-1:0] mask);
		logic [ADDR_W-1:0] a;
		a = addr | (mask >> 1);
		a = a & ~((mask >> 1) ^ mask);
		return a[ADDR_W-1:PAGE_SHIFT];
	endfunction
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	atc_state_e state_q;
	logic ok_q;
	logic pasid_valid_q;
	logic [ADDR_W-1:PAGE_SHIFT] addr_q;
	logic [LEVELS-1:0] flmask_q;
	logic [LVL_W-1:0] leaf_q;
	logic nw_eff;
	logic f_r, f_w, f_exe, f_priv, f_g, f_n, f_u;
	logic r_q, w_q, exe_q, priv_q, g_q, n_q, u_q, s_q;
	logic dirty_q, ea_q;
	logic sl_step, width_fail, np_fail, perm_fail, found_ok;
	logic [WIDTH_W-1:0] lim;
	logic seq_start, seq_done, take;
	// ----------------------------------------------------------------
	// Field computation
	// ----------------------------------------------------------------
	atc_field_calc u_calc (
		.pasid_valid(pasid_valid),
		.xlate_type(xlate_type),
		.no_write_request_flag(no_write_request_flag),
		.no_write_flag_supported(no_write_flag_supported),
		.fetch_intent_requested(fetch_intent_requested),
		.fetch_intent_supported(fetch_intent_supported),
		.supervisor_requested(supervisor_requested),
		.supervisor_mode_capable(supervisor_mode_capable),
		.snoop_control_capable(snoop_control_capable),
		.coherence_override_bit(coherence_override_bit),
		.transient_mapping_bit(transient_mapping_bit),
		.perm_read(perm_read),
		.perm_write(perm_write),
		.perm_exec(perm_exec),
		.any_fl_supervisor(any_fl_supervisor),
		.leaf_global(leaf_global),
		.nw_eff(nw_eff),
		.r_o(f_r),
		.w_o(f_w),
		.exe_o(f_exe),
		.priv_o(f_priv),
		.g_o(f_g),
		.n_o(f_n),
		.u_o(f_u)
	);
	// ----------------------------------------------------------------
	// Success decision
	// ----------------------------------------------------------------
	// Interrupt-window addresses take the same path as any other address
	always_comb begin
		sl_step = !pasid_valid || xlate_type == ATC_XL_NESTED;
		lim = min_w(max_guest_addr_width, adjusted_guest_addr_width);
		width_fail = sl_step && lim < WIDTH_W'(ADDR_W) && (in_addr >> lim) != '0;
		// A used level with both read and write clear is a not-present entry
		np_fail = sl_step && |(~sl_read_bits & ~sl_write_bits & sl_used_mask);
		perm_fail = sl_step && !and_used(sl_read_bits, sl_used_mask)
			&& !and_used(sl_write_bits, sl_used_mask);
		found_ok = walk_found && !width_fail && !np_fail && !perm_fail && (f_r || f_w);
	end
	// Single outstanding request: the endpoint serialises, so no queue is kept
	assign req_ready = state_q == ATC_IDLE;
	// ----------------------------------------------------------------
	// Flag updates
	// ----------------------------------------------------------------
	// Flags only for a successful PASID translation, dirty only if write allowed
	assign seq_start = state_q == ATC_CHECK && ok_q && pasid_valid_q;
	// The walker issues one update per used level and counts the commits
	atc_flag_seq #(.LEVELS(LEVELS)) u_seq (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.start(seq_start),
		.used_mask(flmask_q),
		.leaf_level(leaf_q),
		.set_ext_accessed(ea_q),
		.set_dirty(dirty_q),
		.upd_valid(upd_valid),
		.upd_level(upd_level),
		.upd_set_mask(upd_set_mask),
		.upd_ready(upd_ready),
		.upd_committed(upd_committed),
		.done(seq_done)
	);
	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= ATC_IDLE;
		end else if (ce) begin
			case (state_q)
				ATC_IDLE: begin
					if (req_valid) begin
						state_q <= ATC_CHECK;
					end
				end
				ATC_CHECK: begin
					// Outcome was captured on the accept edge; pick the path from it
					state_q <= seq_start ? ATC_FLAGS : ATC_DONE;
				end
				ATC_FLAGS: begin
					// An empty walk is already done here; waiting on would hang
					if (seq_done) begin
						state_q <= ATC_DONE;
					end else begin
						state_q <= ATC_WAIT;
					end
				end
				ATC_WAIT: begin
					if (seq_done) begin
						state_q <= ATC_DONE;
					end
				end
				ATC_DONE: begin
					// Fields stay frozen until the endpoint side takes them
					if (cpl_ready) begin
						state_q <= ATC_IDLE;
					end
				end
				default: begin
					state_q <= ATC_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Request capture
	// ----------------------------------------------------------------
	// Every capture register loads on the same accept edge
	assign take = ce && req_valid && req_ready;
	// Outcome of the request, held until the completion leaves
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ok_q <= 1'b0;
			pasid_valid_q <= 1'b0;
		end else if (take) begin
			ok_q <= found_ok;
			pasid_valid_q <= pasid_valid;
		end
	end
	// Completion fields; a failed lookup zeroes every one of them
	always_ff @(posedge clk) begin
		if (!resetn) begin
			{r_q, w_q, exe_q, priv_q, g_q, n_q, u_q, s_q} <= 8'h00;
		end else if (take) begin
			if (found_ok) begin
				r_q <= f_r;
				w_q <= f_w;
				exe_q <= f_exe;
				priv_q <= f_priv;
				g_q <= f_g;
				n_q <= f_n;
				u_q <= f_u;
				s_q <= leaf_size_bit;
			end else begin
				{r_q, w_q, exe_q, priv_q, g_q, n_q, u_q, s_q} <= 8'h00;
			end
		end
	end
	// Address is encoded on capture so the data output is a plain flop
	always_ff @(posedge clk) begin
		if (!resetn) begin
			addr_q <= '0;
		end else if (take) begin
			if (found_ok && !f_u) begin
				addr_q <= leaf_size_bit ? size_encode(out_addr, page_mask) : out_addr[ADDR_W-1:PAGE_SHIFT];
			end else begin
				addr_q <= '0;
			end
		end
	end
	// Flag-walker inputs, frozen with the completion fields
	always_ff @(posedge clk) begin
		if (!resetn) begin
			flmask_q <= '0;
			leaf_q <= '0;
			dirty_q <= 1'b0;
			ea_q <= 1'b0;
		end else if (take) begin
			flmask_q <= fl_used_mask;
			leaf_q <= fl_leaf_level;
			ea_q <= extended_accessed_enable;
			dirty_q <= !nw_eff && perm_write;
		end
	end
	// ----------------------------------------------------------------
	// Completion
	// ----------------------------------------------------------------
	// Only the valid strobe decodes state; status is a constant, every other field comes from a flop
	always_comb begin
		cpl_valid = state_q == ATC_DONE;
		cpl_status = CPL_SUCCESS;
		cpl_r = r_q;
		cpl_w = w_q;
		cpl_exe = exe_q;
		cpl_priv = priv_q;
		cpl_g = g_q;
		cpl_n = n_q;
		cpl_u = u_q;
		cpl_s = s_q;
		cpl_addr = addr_q;
	end
endmodule
`default_nettype wire

// ---- rtl/atc_pkg.sv ----
package atc_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 64;
	localparam int PAGE_SHIFT = 12;
	localparam int WIDTH_W = 7;
	localparam int LEVELS = 4;
	localparam int LVL_W = 2;
	// ----------------------------------------------------------------
	// Paging-entry bit positions
	// ----------------------------------------------------------------
	localparam int FL_ACCESSED_BIT = 5;
	localparam int FL_DIRTY_BIT = 6;
	localparam int FL_EXT_ACCESSED_BIT = 10;
	// ----------------------------------------------------------------
	// Completion status
	// ----------------------------------------------------------------
	localparam logic [2:0] CPL_SUCCESS = 3'h0;
	// ----------------------------------------------------------------
	// Translation types and sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ATC_XL_SECOND = 2'h0,
		ATC_XL_FIRST = 2'h1,
		ATC_XL_NESTED = 2'h3
	} atc_xlate_e;
	typedef enum logic [2:0] {
		ATC_IDLE = 3'h0,
		ATC_CHECK = 3'h1,
		ATC_FLAGS = 3'h3,
		ATC_WAIT = 3'h2,
		ATC_DONE = 3'h6
	} atc_state_e;
endpackage

// ---- rtl/atc_field_calc.sv ----
`timescale 1ns/1ps
`default_nettype none
// Combinational completion field computation.
module atc_field_calc (
	input wire logic pasid_valid,
	input wire atc_pkg::atc_xlate_e xlate_type,
	input wire logic no_write_request_flag,
	input wire logic no_write_flag_supported,
	input wire logic fetch_intent_requested,
	input wire logic fetch_intent_supported,
	input wire logic supervisor_requested,
	input wire logic supervisor_mode_capable,
	input wire logic snoop_control_capable,
	input wire logic coherence_override_bit,
	input wire logic transient_mapping_bit,
	input wire logic perm_read,
	input wire logic perm_write,
	input wire logic perm_exec,
	input wire logic any_fl_supervisor,
	input wire logic leaf_global,
	output logic nw_eff,
	output logic r_o,
	output logic w_o,
	output logic exe_o,
	output logic priv_o,
	output logic g_o,
	output logic n_o,
	output logic u_o
);
	import atc_pkg::*;
	always_comb begin
		nw_eff = no_write_request_flag & no_write_flag_supported;
		r_o = perm_read;
		w_o = perm_write & ~nw_eff;
		exe_o = pasid_valid & fetch_intent_requested & fetch_intent_supported & perm_exec;
		priv_o = pasid_valid & supervisor_requested & supervisor_mode_capable & any_fl_supervisor;
		g_o = pasid_valid & leaf_global;
		if (pasid_valid) begin
			n_o = 1'b1;
		end else begin
			n_o = snoop_control_capable & coherence_override_bit;
		end
		if (pasid_valid && xlate_type == ATC_XL_FIRST) begin
			u_o = 1'b0;
		end else begin
			u_o = transient_mapping_bit;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/atc_flag_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
// Walks used first-level entries issuing atomic flag-set requests.
module atc_flag_seq #(
	parameter int LEVELS = atc_pkg::LEVELS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic start,
	input wire logic [LEVELS-1:0] used_mask,
	input wire logic [atc_pkg::LVL_W-1:0] leaf_level,
	input wire logic set_ext_accessed,
	input wire logic set_dirty,
	output logic upd_valid,
	output logic [atc_pkg::LVL_W-1:0] upd_level,
	output logic [2:0] upd_set_mask,
	input wire logic upd_ready,
	input wire logic upd_committed,
	output logic done
);
	import atc_pkg::*;
	logic [LEVELS-1:0] pend_q;
	logic [LVL_W:0] outst_q;
	logic busy_q;
	logic [LVL_W-1:0] sel;
	always_comb begin
		sel = '0;
		for (int i = LEVELS - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				sel = LVL_W'(i);
			end
		end
	end
	assign upd_valid = busy_q & |pend_q;
	assign upd_level = sel;
	// Accessed always, extended-accessed as enabled, dirty as enabled on the leaf level only
	always_comb begin
		upd_set_mask = 3'h1;
		upd_set_mask[1] = set_ext_accessed;
		upd_set_mask[2] = set_dirty && sel == leaf_level;
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pend_q <= '0;
			busy_q <= 1'b0;
		end else if (ce) begin
			if (start) begin
				pend_q <= used_mask;
				busy_q <= 1'b1;
			end else if (upd_valid && upd_ready) begin
				pend_q[sel] <= 1'b0;
			end else if (busy_q && pend_q == '0 && outst_q == '0) begin
				busy_q <= 1'b0;
			end
		end
	end
	// Count issued but uncommitted writes so completion waits for all
	always_ff @(posedge clk) begin
		if (!resetn) begin
			outst_q <= '0;
		end else if (ce) begin
			outst_q <= outst_q + (LVL_W+1)'(upd_valid && upd_ready) - (LVL_W+1)'(upd_committed && outst_q != '0);
		end
	end
	assign done = busy_q && pend_q == '0 && outst_q == '0;
endmodule
`default_nettype wire

// ---- testbench/atc_completion_builder_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module atc_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic pasid_valid,
	input wire atc_pkg::atc_xlate_e xlate_type,
	input wire logic no_write_request_flag,
	input wire logic no_write_flag_supported,
	input wire logic [1:0] fl_leaf_level,
	input wire logic upd_valid,
	input wire logic [1:0] upd_level,
	input wire logic [2:0] upd_set_mask,
	input wire logic upd_ready,
	input wire logic upd_committed,
	input wire logic cpl_valid,
	input wire logic cpl_ready,
	input wire logic [2:0] cpl_status,
	input wire logic cpl_r,
	input wire logic cpl_w,
	input wire logic cpl_exe,
	input wire logic cpl_priv,
	input wire logic cpl_g,
	input wire logic cpl_n,
	input wire logic cpl_u,
	input wire logic cpl_s
);
	import atc_pkg::*;
	logic pas_q, ro_q, first_q;
	logic [1:0] leaf_q;
	logic [3:0] outst_q;
	wire logic take = ce && req_valid && req_ready;
	// Request fields are gone by completion time, so keep a copy
	always_ff @(posedge clk) begin
		if (take) begin
			pas_q <= pasid_valid;
			ro_q <= no_write_request_flag && no_write_flag_supported;
			first_q <= xlate_type == ATC_XL_FIRST;
			leaf_q <= fl_leaf_level;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn)
			outst_q <= 4'h0;
		else if (ce)
			outst_q <= outst_q + 4'(upd_valid && upd_ready) - 4'(upd_committed && outst_q != 4'h0);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence take_s; take && !pasid_valid; endsequence
	sequence stall_s; cpl_valid && !cpl_ready; endsequence
	fast_cpl_a: assert property (take_s |-> ##2 cpl_valid) else $error("late completion");
	cpl_hold_a: assert property (stall_s |=> cpl_valid && $stable({cpl_r, cpl_w, cpl_u, cpl_s, cpl_n}))
		else $error("completion moved");
	upd_hold_a: assert property (upd_valid && !upd_ready |=> upd_valid && $stable({upd_level, upd_set_mask}))
		else $error("update moved");
	status_ok_a: assert property (cpl_valid |-> cpl_status == CPL_SUCCESS) else $error("bad status");
	fail_zero_a: assert property (cpl_valid && !cpl_r && !cpl_w && !ro_q |-> !cpl_u && !cpl_s)
		else $error("failure fields");
	pasid_n_a: assert property (cpl_valid && pas_q && (cpl_r || cpl_w) |-> cpl_n) else $error("n clear");
	no_pasid_a: assert property (cpl_valid && !pas_q |-> !cpl_exe && !cpl_priv && !cpl_g)
		else $error("pasid-only bit set");
	first_u_a: assert property (cpl_valid && pas_q && first_q |-> !cpl_u) else $error("u on first level");
	ro_write_a: assert property (cpl_valid && ro_q |-> !cpl_w) else $error("w on read-only");
	upd_pasid_a: assert property (upd_valid |-> pas_q) else $error("update without pasid");
	dirty_leaf_a: assert property (upd_valid && upd_set_mask[2] |-> upd_level == leaf_q && !ro_q)
		else $error("stray dirty");
	commit_first_a: assert property ($rose(cpl_valid) |-> outst_q == 4'h0) else $error("early completion");
endmodule
bind atc_completion_builder atc_chk u_chk (.*);
`default_nettype wire

// ---- testbench/atc_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module atc_mem_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic upd_valid,
	output logic upd_ready,
	output logic upd_committed
);
	logic tick_q;
	logic [2:0] pipe_q;
	// Slow mode accepts every other cycle so held requests get exercised
	assign upd_ready = upd_valid && (!slow || tick_q);
	assign upd_committed = pipe_q[2];
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tick_q <= 1'b0;
			pipe_q <= 3'h0;
		end else begin
			tick_q <= !tick_q;
			pipe_q <= {pipe_q[1:0], upd_ready};
		end
	end
endmodule
`default_nettype wire

// ---- testbench/atc_completion_builder_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module atc_completion_builder_bench;
	import atc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic slow, req_valid, req_ready, pasid_valid, no_write_request_flag, fetch_intent_requested;
	logic supervisor_requested, no_write_flag_supported, fetch_intent_supported, supervisor_mode_capable;
	logic snoop_control_capable, extended_accessed_enable, walk_found, perm_read, perm_write, perm_exec;
	logic any_fl_supervisor, leaf_global, coherence_override_bit, transient_mapping_bit, leaf_size_bit;
	logic upd_valid, upd_ready, upd_committed, cpl_valid, cpl_ready;
	logic cpl_r, cpl_w, cpl_exe, cpl_priv, cpl_g, cpl_n, cpl_u, cpl_s;
	atc_xlate_e xlate_type;
	logic [6:0] max_guest_addr_width, adjusted_guest_addr_width;
	logic [63:0] in_addr, out_addr, page_mask, e_addr;
	logic [3:0] sl_read_bits, sl_write_bits, sl_used_mask, fl_used_mask;
	logic [1:0] fl_leaf_level, upd_level;
	logic [2:0] upd_set_mask, cpl_status;
	logic [63:12] cpl_addr;
	logic [2:0] seen [4];
	int n_errors = 0, comparisons = 0, cyc = 0, lat;
	atc_completion_builder dut (.*);
	atc_mem_model pm (.*);
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (upd_valid && upd_ready)
			seen[upd_level] <= upd_set_mask;
		if (cyc == 3000) begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			close_out();
		end
	end
	task automatic chkv(input logic [63:0] got, input logic [63:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h", $time, what, got);
		end
	endtask
	// One whole transfer; completion is held a cycle before acceptance
	task automatic req(input int exp_lat, input logic [7:0] eb);
		@(negedge clk);
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		lat = 1;
		while (!cpl_valid && lat < 200) begin
			@(negedge clk);
			lat++;
		end
		if (exp_lat > 0)
			chkv(64'(lat), 64'(exp_lat), "latency");
		@(negedge clk);
		chkv({cpl_valid, req_ready, cpl_status}, {2'b10, CPL_SUCCESS}, "handshake");
		chkv({cpl_r, cpl_w, cpl_exe, cpl_priv, cpl_g, cpl_n, cpl_u, cpl_s}, eb, "bits");
		e_addr = (out_addr | (page_mask >> 1)) & ~(page_mask & ~(page_mask >> 1));
		if ((eb[7] || eb[6]) && !eb[1])
			chkv(cpl_addr, e_addr[63:12], "address");
		cpl_ready = 1'b1;
		@(negedge clk);
		cpl_ready = 1'b0;
		$display("test done at %0t", $time);
	endtask
	task automatic close_out;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{slow, req_valid, cpl_ready, pasid_valid, no_write_request_flag, fetch_intent_requested,
			supervisor_requested, no_write_flag_supported, fetch_intent_supported, supervisor_mode_capable,
			extended_accessed_enable, perm_exec, any_fl_supervisor, transient_mapping_bit} = '0;
		{walk_found, perm_read, perm_write, snoop_control_capable, coherence_override_bit, leaf_global} = '1;
		{sl_read_bits, sl_write_bits, sl_used_mask, fl_used_mask} = '1;
		xlate_type = ATC_XL_SECOND;
		{max_guest_addr_width, adjusted_guest_addr_width} = {7'd48, 7'd48};
		in_addr = 64'h1234_5000;
		fl_leaf_level = 2'h3;
		out_addr = 64'h12_3450_0000;
		page_mask = 64'h1f_ffff;
		leaf_size_bit = 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		req(2, 8'b1100_0101);
		{snoop_control_capable, perm_write, leaf_size_bit, transient_mapping_bit} = 4'b0001;
		page_mask = 64'hfff;
		req(2, 8'b1000_0010);
		leaf_size_bit = 1'b1;
		perm_write = 1'b1;
		// Over-width, not-present entry, ANDed permissions clear, nothing found
		for (int k = 0; k < 4; k++) begin
			adjusted_guest_addr_width = (k == 0) ? 7'd40 : 7'd48;
			in_addr = (k == 0) ? 64'h100_0000_0000 : 64'h1000;
			sl_read_bits = (k == 1) ? 4'hd : (k == 2) ? 4'he : 4'hf;
			sl_write_bits = (k == 1 || k == 2) ? 4'hd : 4'hf;
			walk_found = k != 3;
			req(2, 8'h00);
		end
		// Accept edges with ce low must not take the request
		{ce, req_valid} = 2'b01;
		repeat (3) @(negedge clk);
		chkv({req_ready, cpl_valid, upd_valid}, 3'b100, "frozen");
		{ce, req_valid} = 2'b10;
		$display("hold test done at %0t", $time);
		walk_found = 1'b1;
		{pasid_valid, fetch_intent_requested, fetch_intent_supported, perm_exec, supervisor_requested,
			supervisor_mode_capable, any_fl_supervisor, extended_accessed_enable, slow} = '1;
		xlate_type = ATC_XL_FIRST;
		{leaf_size_bit, fl_used_mask, fl_leaf_level} = {1'b0, 4'h7, 2'h2};
		in_addr = 64'hfee0_1000;
		page_mask = 64'hfff;
		seen = '{default: 3'h0};
		req(0, 8'b1111_1100);
		chkv({seen[0], seen[1], seen[2], seen[3]}, 12'b011_011_111_000, "flags");
		for (int k = 0; k < 2; k++) begin
			{no_write_request_flag, fetch_intent_supported, supervisor_mode_capable} = 3'b100;
			{extended_accessed_enable, slow, transient_mapping_bit} = 3'b001;
			no_write_flag_supported = k == 0;
			xlate_type = ATC_XL_NESTED;
			{fl_used_mask, fl_leaf_level} = {4'h3, 2'h1};
			seen = '{default: 3'h0};
			req(0, {1'b1, k == 1, 6'b001110});
			chkv({seen[0], seen[1]}, {3'b001, k == 1, 2'b01}, "flags");
		end
		close_out();
	end
endmodule
`default_nettype wire
